/* File: hdl/auto_run_sequencer.sv */
`timescale 1ns/100ps
`include "auto_run_regs.svh"
module auto_run_sequencer
  import auto_run_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `AR_TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // run command and step 0 frequency from the drive
  input wire logic run_cmd,
  input wire logic [15:0] base_freq,
  // command to the speed control stage
  output logic seq_active,
  output logic [15:0] freq_cmd,
  output logic [1:0] dir_cmd,
  output logic [2:0] step_num,
  output logic cycle_done
);

  // register storage
  run_mode_e mode_ff;
  // frequency of steps 1..7, step 0 uses base_freq
  step_val_t freq_ff [1:7];
  // duration of each step in 0.1 s units
  step_val_t time_ff [0:7];
  // direction of each step
  rot_dir_e dir_ff [0:7];

  // sequencer state
  seq_state_e state_ff, nxt_state;
  logic [2:0] step_ff, nxt_step;
  step_val_t elapsed_ff, nxt_elapsed;
  // an interrupted step waits to be resumed
  logic resume_ff, nxt_resume;
  logic done_ff, nxt_done;
  logic run_q_ff;

  // outputs
  logic seq_active_ff;
  logic [15:0] freq_cmd_ff;
  logic [1:0] dir_cmd_ff;
  logic [2:0] step_num_ff;

  // decode helpers
  logic tick;
  logic start;
  logic mode_off;
  logic resume_mode;
  logic loop_mode;
  logic hold_mode;
  logic step_end;

  reg_access_if rif ();

  // clamp a written value to its documented range
  function automatic step_val_t clamp16(input logic [15:0] val,
      input logic [15:0] max);
    clamp16 = (val > max) ? max : val;
  endfunction

  // true when a byte offset names one of the step registers
  function automatic logic is_step(input logic [7:0] ofs);
    is_step = (ofs >= `AR_STEP0_OFS) && (ofs <= `AR_STEP7_OFS);
  endfunction

  // step number of a step register offset
  function automatic logic [2:0] step_of(input logic [7:0] ofs);
    logic [7:0] rel;
    rel = ofs - `AR_STEP0_OFS;
    step_of = rel[4:2];
  endfunction

  // a code of 3 is not a direction, it is taken as stop
  function automatic rot_dir_e dir_code(input logic [1:0] code);
    dir_code = (code == 2'h3) ? DIR_STOP : rot_dir_e'(code);
  endfunction

  // frequency that a step drives
  function automatic step_val_t step_freq(input logic [2:0] idx);
    step_freq = (idx == 3'h0) ? base_freq : freq_ff[idx];
  endfunction

  // bus slave front end
  ahb_reg_port u_bus (
    .core_clk (core_clk),
    .srst (srst),
    .hsel (hsel),
    .haddr (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hwdata (hwdata),
    .hready (hready),
    .hrdata (hrdata),
    .hreadyout (hreadyout),
    .hresp (hresp),
    .rif (rif.bus)
  );

  // 0.1 s time base, only runs while a step is timing
  tick_divider #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .srst (srst),
    .enable (state_ff == ST_RUN),
    .tick (tick)
  );

  // mode register, values above six are ignored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_ff <= run_mode_e'(`AR_MODE_RST);
    end else if (rif.wr_en && (rif.wr_ofs == `AR_CTRL_OFS)) begin
      if (rif.wr_data[2:0] <= `AR_MODE_MAX) begin
        mode_ff <= run_mode_e'(rif.wr_data[2:0]);
      end
    end
  end

  // per-step frequency and duration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        time_ff[i] <= `AR_TIME_RST;
      end
      for (int i = 1; i < 8; i++) begin
        freq_ff[i] <= `AR_FREQ_RST;
      end
    end else if (rif.wr_en && is_step(rif.wr_ofs)) begin
      time_ff[step_of(rif.wr_ofs)] <= clamp16(
        rif.wr_data[`AR_TIME_LSB +: 16], `AR_TIME_MAX);
      if (step_of(rif.wr_ofs) != 3'h0) begin
        freq_ff[step_of(rif.wr_ofs)] <= clamp16(
          rif.wr_data[`AR_FREQ_LSB +: 16], `AR_FREQ_MAX);
      end
    end
  end

  // direction codes, two bits per step
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        dir_ff[i] <= DIR_STOP;
      end
    end else if (rif.wr_en && (rif.wr_ofs == `AR_DIR_OFS)) begin
      for (int i = 0; i < 8; i++) begin
        dir_ff[i] <= dir_code(rif.wr_data[2*i +: 2]);
      end
    end
  end

  // register read data, unmapped offsets read zero
  always_comb begin
    rif.rd_data = 32'h0;
    if (rif.rd_ofs == `AR_CTRL_OFS) begin
      rif.rd_data = {29'h0, mode_ff};
    end else if (rif.rd_ofs == `AR_STATUS_OFS) begin
      rif.rd_data = {23'h0, step_ff, resume_ff, done_ff, state_ff};
    end else if (rif.rd_ofs == `AR_DIR_OFS) begin
      for (int i = 0; i < 8; i++) begin
        rif.rd_data[2*i +: 2] = dir_ff[i];
      end
    end else if (rif.rd_ofs == `AR_ELAPSED_OFS) begin
      rif.rd_data = {16'h0, elapsed_ff};
    end else if (is_step(rif.rd_ofs)) begin
      rif.rd_data[`AR_TIME_LSB +: 16] = time_ff[step_of(rif.rd_ofs)];
      if (step_of(rif.rd_ofs) != 3'h0) begin
        rif.rd_data[`AR_FREQ_LSB +: 16] = freq_ff[step_of(rif.rd_ofs)];
      end
    end
  end

  // mode decode
  assign mode_off = (mode_ff == MODE_OFF);
  assign resume_mode = (mode_ff == MODE_ONCE_RESUME) ||
    (mode_ff == MODE_LOOP_RESUME) || (mode_ff == MODE_HOLD_RESUME);
  assign loop_mode = (mode_ff == MODE_LOOP_RESUME) ||
    (mode_ff == MODE_LOOP_FRESH);
  assign hold_mode = (mode_ff == MODE_HOLD_RESUME) ||
    (mode_ff == MODE_HOLD_FRESH);
  // a start is the rising edge of the run command
  assign start = run_cmd && !run_q_ff;
  // step ends once its duration is used up
  assign step_end = (elapsed_ff >= time_ff[step_ff]);

  // run command edge detect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_q_ff <= 1'b0;
    end else begin
      run_q_ff <= run_cmd;
    end
  end

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_elapsed = elapsed_ff;
    nxt_resume = resume_ff;
    nxt_done = done_ff;
    case (state_ff)
      ST_IDLE: begin
        // no start while mode is zero
        if (start && !mode_off) begin
          nxt_state = ST_RUN;
          nxt_done = 1'b0;
          nxt_resume = 1'b0;
          // resume modes keep the unfinished step
          // fresh modes always restart at step 0
          if (!(resume_mode && resume_ff)) begin
            nxt_step = 3'h0;
            nxt_elapsed = 16'h0;
          end
        end
      end
      ST_RUN: begin
        if (mode_off) begin
          nxt_state = ST_IDLE;
          nxt_resume = 1'b0;
          nxt_step = 3'h0;
          nxt_elapsed = 16'h0;
        end else if (!run_cmd) begin
          // keep step and time for a resume
          nxt_state = ST_IDLE;
          nxt_resume = 1'b1;
        end else if (step_end) begin
          nxt_elapsed = 16'h0;
          if (step_ff != 3'h7) begin
            nxt_step = step_ff + 3'h1;
          end else if (loop_mode) begin
            // periodic modes wrap to step 0
            nxt_step = 3'h0;
          end else if (hold_mode) begin
            // keep running at the final step
            nxt_state = ST_HOLD;
          end else begin
            nxt_state = ST_DONE;
            nxt_done = 1'b1;
          end
        end else if (tick) begin
          nxt_elapsed = elapsed_ff + 16'h1;
        end
      end
      ST_HOLD: begin
        // a finished hold always restarts fresh
        if (mode_off || !run_cmd) begin
          nxt_state = ST_IDLE;
          nxt_resume = 1'b0;
          nxt_step = 3'h0;
        end
      end
      ST_DONE: begin
        // wait for the run command to drop before a new cycle
        if (mode_off || !run_cmd) begin
          nxt_state = ST_IDLE;
          nxt_resume = 1'b0;
          nxt_step = 3'h0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // sequencer state registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      step_ff <= 3'h0;
      elapsed_ff <= 16'h0;
      resume_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      elapsed_ff <= nxt_elapsed;
      resume_ff <= nxt_resume;
      done_ff <= nxt_done;
    end
  end

  // drive command, built from next state so it lines up with it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      seq_active_ff <= 1'b0;
      freq_cmd_ff <= 16'h0;
      dir_cmd_ff <= DIR_STOP;
      step_num_ff <= 3'h0;
    end else begin
      step_num_ff <= nxt_step;
      if (nxt_state == ST_RUN) begin
        seq_active_ff <= 1'b1;
        freq_cmd_ff <= step_freq(nxt_step);
        dir_cmd_ff <= dir_ff[nxt_step];
      end else if (nxt_state == ST_HOLD) begin
        seq_active_ff <= 1'b1;
        freq_cmd_ff <= step_freq(3'h7);
        dir_cmd_ff <= dir_ff[7];
      end else begin
        seq_active_ff <= 1'b0;
        freq_cmd_ff <= 16'h0;
        dir_cmd_ff <= DIR_STOP;
      end
    end
  end

  assign seq_active = seq_active_ff;
  assign freq_cmd = freq_cmd_ff;
  assign dir_cmd = dir_cmd_ff;
  assign step_num = step_num_ff;
  assign cycle_done = done_ff;
endmodule // auto_run_sequencer

/* File: hdl/auto_run_regs.svh */
// What this block does
// - mode zero keeps the sequencer idle
// - mode one: one pass, restart resumes
// - mode two: repeats, restart resumes
// - mode three: one pass, hold last
// - mode four: one pass, restart fresh
// - mode five: repeats, restart fresh
// - mode six: hold last, restart fresh
// - frequency per step 1..7, 0..599.00 Hz
// - duration per step 0..7, 0..3600.0 s
// - direction code stop, forward, reverse
// - direction code per step 0..7, all held in one register
`ifndef AUTO_RUN_REGS_SVH
`define AUTO_RUN_REGS_SVH
// byte offsets on the register bus
`define AR_CTRL_OFS 8'h00
`define AR_STATUS_OFS 8'h04
`define AR_DIR_OFS 8'h08
`define AR_ELAPSED_OFS 8'h0C
`define AR_STEP0_OFS 8'h10
`define AR_STEP7_OFS 8'h2C
// field positions in a step register
`define AR_FREQ_LSB 0
`define AR_TIME_LSB 16
// reset values and ranges
`define AR_MODE_RST 3'h0
`define AR_FREQ_RST 16'h0000
`define AR_TIME_RST 16'h0000
`define AR_FREQ_MAX 16'hE9FC
`define AR_TIME_MAX 16'h8CA0
`define AR_MODE_MAX 3'h6
// timing: one duration unit is 0.1 s
`define AR_TIME_UNIT_NS 100000000
`define AR_CLK_PERIOD_NS 5
`define AR_TICK_CYCLES \
  ((`AR_TIME_UNIT_NS + `AR_CLK_PERIOD_NS - 1) / `AR_CLK_PERIOD_NS)
`endif

/* File: hdl/auto_run_pkg.sv */
package auto_run_pkg;
  // sequencer mode setting
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_ONCE_RESUME = 3'h1,
    MODE_LOOP_RESUME = 3'h2,
    MODE_HOLD_RESUME = 3'h3,
    MODE_ONCE_FRESH = 3'h4,
    MODE_LOOP_FRESH = 3'h5,
    MODE_HOLD_FRESH = 3'h6
  } run_mode_e;
  // step direction code
  typedef enum logic [1:0] {
    DIR_STOP = 2'h0,
    DIR_FWD = 2'h1,
    DIR_REV = 2'h2
  } rot_dir_e;
  // one-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_HOLD = 4'h4,
    ST_DONE = 4'h8
  } seq_state_e;
  // step frequency or duration value
  typedef logic [15:0] step_val_t;
endpackage

/* File: hdl/reg_access_if.sv */
`timescale 1ns/100ps
interface reg_access_if;
  logic wr_en;
  logic [7:0] wr_ofs;
  logic [31:0] wr_data;
  logic [7:0] rd_ofs;
  logic [31:0] rd_data;
  modport bus (output wr_en, output wr_ofs, output wr_data,
    output rd_ofs, input rd_data);
  modport regs (input wr_en, input wr_ofs, input wr_data,
    input rd_ofs, output rd_data);
endinterface

/* File: hdl/tick_divider.sv */
`timescale 1ns/100ps
module tick_divider #(
  parameter int unsigned TICK_CYCLES = 20000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // count only while enabled
  input wire logic enable,
  output logic tick
);
  // cycles into the current unit
  logic [31:0] cnt_ff;
  logic tick_ff;

  // a pause drops the partial unit, so timing restarts clean
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == 32'(TICK_CYCLES - 1)) begin
      cnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;
endmodule // tick_divider

/* File: hdl/ahb_reg_port.sv */
`timescale 1ns/100ps
module ahb_reg_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // register file side
  reg_access_if.bus rif
);
  logic take;
  logic in_map;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic rd_map_ff;
  logic [7:0] ofs_ff;
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic hresp_ff;

  // address phase accepted on a nonseq/seq transfer
  assign take = hsel && hready && htrans[1];
  // only aligned words in the first 256 bytes are mapped
  assign in_map = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);

  // capture the address phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rd_map_ff <= 1'b0;
      ofs_ff <= 8'h0;
    end else begin
      wr_pend_ff <= take && hwrite && in_map;
      rd_pend_ff <= take && !hwrite;
      rd_map_ff <= in_map;
      if (take) begin
        ofs_ff <= haddr[7:0];
      end
    end
  end

  // reads wait one cycle so a write just before is visible
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h0;
    end else if (take && !hwrite) begin
      hready_ff <= 1'b0;
    end else if (rd_pend_ff) begin
      hready_ff <= 1'b1;
      hrdata_ff <= rd_map_ff ? rif.rd_data : 32'h0;
    end
  end

  // the response is always okay
  always_ff @(posedge core_clk) begin
    hresp_ff <= 1'b0;
  end

  assign rif.wr_en = wr_pend_ff;
  assign rif.wr_ofs = ofs_ff;
  assign rif.wr_data = hwdata;
  assign rif.rd_ofs = ofs_ff;
  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
endmodule // ahb_reg_port

/* File: sim/auto_run_monitor.sv */
`timescale 1ns/100ps
module auto_run_monitor #(
  parameter int unsigned TICK_CYCLES = 20000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bus handshake
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // run link
  input wire logic run_cmd,
  input wire logic seq_active,
  input wire logic [15:0] freq_cmd,
  input wire logic [1:0] dir_cmd,
  input wire logic [2:0] step_num,
  input wire logic cycle_done
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // accepted read and write requests
  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_take;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  // reads take exactly one wait state
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (rd_take |=> rd_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
  chk_idle_zero: assert property (
    !seq_active |-> freq_cmd == 16'h0000 && dir_cmd == 2'h0)
    else $error("command while inactive");
  chk_dir_legal: assert property (seq_active |-> dir_cmd != 2'h3)
    else $error("illegal direction code");
  chk_step_order: assert property (seq_active && $past(seq_active) &&
    $changed(step_num) |-> step_num == 3'($past(step_num) + 3'h1))
    else $error("step skipped or reversed");
  chk_freq_max: assert property (
    seq_active && step_num != 3'h0 |-> freq_cmd <= 16'hE9FC)
    else $error("frequency above range");
  chk_done_idle: assert property (cycle_done |-> !seq_active)
    else $error("running after single pass");
  // three cycles of stop leave the sequencer idle
  chk_stop_drop: assert property ((!run_cmd) [*3] |-> !seq_active)
    else $error("still running after stop");
endmodule // auto_run_monitor
bind auto_run_sequencer auto_run_monitor #(.TICK_CYCLES(TICK_CYCLES))
  auto_run_monitor_i (.core_clk, .srst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .run_cmd, .seq_active, .freq_cmd, .dir_cmd,
  .step_num, .cycle_done);

/* File: sim/drive_model.sv */
`timescale 1ns/100ps
module drive_model (
  // clock
  input wire logic core_clk,
  // requests from the bench
  input wire logic run_req,
  input wire logic [15:0] base_set,
  // run command and step 0 frequency
  output logic run_cmd,
  output logic [15:0] base_freq
);
  // start stopped, like a switch at power up
  initial begin
    run_cmd = 1'b0;
    base_freq = 16'h0000;
  end
  // terminal inputs arrive one cycle late, as after a resync stage
  always @(posedge core_clk) begin
    run_cmd <= run_req;
    base_freq <= base_set;
  end
endmodule // drive_model

/* File: sim/auto_run_sequencer_tb.sv */
`timescale 1ns/100ps
module auto_run_sequencer_tb;
  import auto_run_pkg::*;
  localparam int TK = 4; // short tick keeps the run brief
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, run_cmd, seq_active, cycle_done;
  logic run_req = 1'b0;
  logic [15:0] base_set = 16'h0;
  logic [15:0] base_freq, freq_cmd;
  logic [1:0] dir_cmd;
  logic [2:0] step_num;
  logic [31:0] exp_q[$]; // notes of expected results
  logic [15:0] fq[8];
  logic [1:0] dq[8];
  logic rd_dp = 1'b0; // read data phase pending
  logic act_q = 1'b0;
  logic [2:0] stp_q = 3'h0;
  int num_errors = 0;
  int n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  auto_run_sequencer #(.TICK_CYCLES(TK)) auto_run_sequencer_i (
    .core_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .run_cmd,
    .base_freq, .seq_active, .freq_cmd, .dir_cmd, .step_num, .cycle_done);
  drive_model drive_model_i (.core_clk, .run_req, .base_set, .run_cmd,
    .base_freq);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one single transfer; waits on hready, never on a fixed count
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (!hreadyout);
    hsel <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  // step note: step number, direction, frequency
  task automatic note(logic [2:0] s);
    exp_q.push_back({11'h0, s, dq[s], s == 3'h0 ? base_set : fq[s]});
  endtask
  task automatic wait_q();
    int i;
    for (i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge core_clk);
    chk("pending notes", 32'h0, exp_q.size());
  endtask
  // watcher: read data at completion, step output at each new step
  always @(posedge core_clk) begin
    if (rd_dp && hreadyout) begin
      rd_dp <= 1'b0;
      chk("hrdata", exp_q.pop_front(), hrdata);
    end
    if (hsel && htrans[1] && !hwrite && hreadyout) rd_dp <= 1'b1;
    if (seq_active && (!act_q || step_num != stp_q) && exp_q.size() > 0)
      chk("step", exp_q.pop_front(),
        {11'h0, step_num, dir_cmd, freq_cmd});
    act_q <= seq_active;
    stp_q <= step_num;
  end
  // watchdog well beyond the expected run length
  initial begin
    #60000;
    num_errors++;
    test_done();
  end
  initial begin
    int m, s, i;
    logic [15:0] dw;
    void'($urandom(14723));
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    // reset values: mode off, idle, all zero and stop
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h10, 32'h0);
    // out of range settings are refused or clamped
    ahb(1'b1, 8'h00, 32'h7);
    rd(8'h00, 32'h0);
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h8CA0E9FC);
    ahb(1'b1, 8'h08, 32'hFFFF);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    // mode zero ignores the run command
    run_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("active in mode 0", 32'h0, seq_active);
    run_req <= 1'b0;
    base_set <= 16'($urandom % 59901);
    dw = 16'h0;
    for (s = 0; s < 8; s++) begin
      fq[s] = 16'($urandom % 59901);
      dq[s] = 2'($urandom % 3);
      dw[2*s +: 2] = dq[s];
      ahb(1'b1, 8'(8'h10 + 4 * s), {16'h1, fq[s]});
    end
    ahb(1'b1, 8'h08, {16'h0, dw});
    rd(8'h08, {16'h0, dw});
    rd(8'h10, 32'h00010000);
    // modes 1 to 6: stop in step 3, restart, run to the end
    for (m = 1; m < 7; m++) begin
      ahb(1'b1, 8'h00, 32'(m));
      for (s = 0; s < 4; s++) note(3'(s));
      run_req <= 1'b1;
      for (i = 0; i < 300 && !(seq_active && step_num == 3'h3); i++)
        @(posedge core_clk);
      run_req <= 1'b0;
      repeat (4) @(posedge core_clk);
      // resume modes go on in step 3, fresh modes restart at step 0
      for (s = (m < 4) ? 3 : 0; s < 8; s++) note(3'(s));
      if (m == 2 || m == 5) note(3'h0);
      run_req <= 1'b1;
      wait_q();
      if (m == 1 || m == 4) begin
        for (i = 0; i < 40 && cycle_done !== 1'b1; i++) @(posedge core_clk);
        chk("single pass done", 32'h1, cycle_done);
      end else if (m == 3 || m == 6) begin
        repeat (TK * 3 + 4) @(posedge core_clk);
        chk("hold", {10'h0, 1'b1, 3'h7, dq[7], fq[7]},
          {10'h0, seq_active, step_num, dir_cmd, freq_cmd});
        // status must show the hold state, not a step still timing
        rd(8'h04, 32'h000001C4);
      end else begin
        chk("loop running", 32'h1, seq_active);
        // mode zero abandons the loop, so the next mode starts clean
        ahb(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("off abandons", 32'h0, seq_active);
        rd(8'h04, 32'h1);
      end
      run_req <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    // a second reset with the sequencer stopped brings every setting back to default
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h08, 32'h0);
    wait_q();
    test_done();
  end
endmodule // auto_run_sequencer_tb
